// ---- sle_params.svh ----
`ifndef SLE_PARAMS_SVH
`define SLE_PARAMS_SVH

// Clock rate and the base tick of all indicator patterns.
`define SLE_CLK_HZ          25000000
`define SLE_TICK_US         1000

// Pattern half periods and flash length, counted in base ticks (ms).
`define SLE_FAST_HALF_MS    10'h064
`define SLE_SLOW_HALF_MS    10'h1f4
`define SLE_SLOWER_HALF_MS  10'h3e8
`define SLE_SHORT_MS        6'h32

// Add-on module type codes reported by discovery.
`define SLE_TYPE_NONE       2'h0
`define SLE_TYPE_DIGITAL    2'h1
`define SLE_TYPE_ANALOG     2'h2
`define SLE_TYPE_RELAY      2'h3

// Pins per add-on type.
`define SLE_PINS_DIGITAL    8'h20
`define SLE_PINS_ANALOG     8'h08
`define SLE_PINS_RELAY      8'h10

// Number of add-on slots and CAN channels.
`define SLE_SLOTS           4
`define SLE_CHANS           4

`endif

// ---- sle_pkg.sv ----
package sle_pkg;

  typedef struct packed {
    logic [14:0]     tick_cnt;
    logic            tick;
    logic [9:0]      fast_cnt;
    logic            fast;
    logic [9:0]      slow_cnt;
    logic            slow;
    logic [9:0]      slower_cnt;
    logic            slower;
    logic [3:0][5:0] flash_cnt;
    logic [3:0]      pres;
    logic [7:0]      types;
    logic [3:0][7:0] base;
    logic [7:0]      total;
    logic            clr;
    logic            pwr_led;
    logic            link_led;
    logic [3:0]      red;
    logic [3:0]      yel;
    logic [3:0]      addon;
  } sle_state_t;

endpackage : sle_pkg

// ---- sle_top.sv ----
`include "sle_params.svh"

module sle_top #(
  parameter int unsigned TICK_CYC = (`SLE_CLK_HZ / 1000000) * `SLE_TICK_US
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  // Unit and network state
  input  wire logic        PWR_OK_I,
  input  wire logic        NET_WAIT_LEASE_I,
  input  wire logic        NET_READY_I,
  input  wire logic        NET_CONNECTED_I,
  // CAN controller state
  input  wire logic [3:0]  CAN_ERR_PASSIVE_I,
  input  wire logic [3:0]  CAN_BUS_OFF_I,
  input  wire logic [3:0]  CAN_ERR_FRAME_I,
  // Add-on discovery
  input  wire logic [3:0]  MOD_PRESENT_I,
  input  wire logic [7:0]  MOD_TYPE_I,
  input  wire logic [3:0]  MOD_COMM_I,
  // Indicators
  output logic             POWER_INDICATOR_O,
  output logic             LINK_INDICATOR_O,
  output logic [3:0]       CAN_RED_O,
  output logic [3:0]       CAN_YEL_O,
  output logic [3:0]       ADDON_POWER_INDICATOR_O,
  // Pin enumeration
  output logic [31:0]      PIN_BASE_O,
  output logic [7:0]       PIN_TOTAL_O,
  output logic             OUT_CLEAR_O
);

  sle_pkg::sle_state_t st_r;
  sle_pkg::sle_state_t st_nxt;

  // Advances a half-period counter on each tick and flips its phase at the end.
  function automatic logic [10:0] sle_step(
    input logic [9:0] cnt,
    input logic       ph,
    input logic       tk,
    input logic [9:0] half
  );
    logic [10:0] r;
    r = {ph, cnt};
    if (tk)
    begin
      if (cnt >= half - 10'h001)
        r = {~ph, 10'h000};
      else
        r = {ph, cnt + 10'h001};
    end
    return r;
  endfunction : sle_step

  // Pin count of one add-on type; an unknown type contributes no pins.
  function automatic logic [7:0] sle_pins(input logic [1:0] t);
    logic [7:0] n;
    case (t)
      `SLE_TYPE_DIGITAL: n = `SLE_PINS_DIGITAL;
      `SLE_TYPE_ANALOG:  n = `SLE_PINS_ANALOG;
      `SLE_TYPE_RELAY:   n = `SLE_PINS_RELAY;
      default:           n = 8'h00;
    endcase
    return n;
  endfunction : sle_pins

  always_comb
  begin
    logic [10:0] s;
    logic [7:0]  acc;
    logic        chain;
    s      = 11'h000;
    acc    = 8'h00;
    chain  = 1'b1;
    st_nxt = st_r;

    // One shared millisecond tick keeps every pattern in phase across channels.
    st_nxt.tick = 1'b0;
    if (st_r.tick_cnt == 15'(TICK_CYC - 1))
    begin
      st_nxt.tick_cnt = 15'h0000;
      st_nxt.tick     = 1'b1;
    end
    else
    begin
      st_nxt.tick_cnt = st_r.tick_cnt + 15'h0001;
    end

    s = sle_step(st_r.fast_cnt, st_r.fast, st_r.tick, `SLE_FAST_HALF_MS);
    st_nxt.fast     = s[10];
    st_nxt.fast_cnt = s[9:0];
    s = sle_step(st_r.slow_cnt, st_r.slow, st_r.tick, `SLE_SLOW_HALF_MS);
    st_nxt.slow     = s[10];
    st_nxt.slow_cnt = s[9:0];
    s = sle_step(st_r.slower_cnt, st_r.slower, st_r.tick, `SLE_SLOWER_HALF_MS);
    st_nxt.slower     = s[10];
    st_nxt.slower_cnt = s[9:0];

    st_nxt.pwr_led = PWR_OK_I;

    // Connection outranks readiness, which outranks waiting for a lease.
    if (NET_CONNECTED_I)
      st_nxt.link_led = 1'b1;
    else if (NET_READY_I)
      st_nxt.link_led = st_r.slow;
    else if (NET_WAIT_LEASE_I)
      st_nxt.link_led = st_r.fast;
    else
      st_nxt.link_led = 1'b0;

    for (int c = 0; c < `SLE_CHANS; c++)
    begin
      // A new error frame restarts the flash rather than being lost.
      if (CAN_ERR_FRAME_I[c])
        st_nxt.flash_cnt[c] = `SLE_SHORT_MS;
      else if (st_r.tick && st_r.flash_cnt[c] != 6'h00)
        st_nxt.flash_cnt[c] = st_r.flash_cnt[c] - 6'h01;
      if (CAN_BUS_OFF_I[c])
      begin
        st_nxt.red[c] = st_r.slower;
        st_nxt.yel[c] = st_r.slow;
      end
      else if (CAN_ERR_PASSIVE_I[c])
      begin
        st_nxt.red[c] = st_r.slow;
        st_nxt.yel[c] = st_r.slow;
      end
      else
      begin
        st_nxt.red[c] = 1'b0;
        st_nxt.yel[c] = 1'b0;
      end
      if (st_r.flash_cnt[c] != 6'h00)
        st_nxt.red[c] = 1'b1;
    end

    for (int m = 0; m < `SLE_SLOTS; m++)
    begin
      if (!MOD_PRESENT_I[m])
        st_nxt.addon[m] = 1'b0;
      else if (MOD_COMM_I[m])
        st_nxt.addon[m] = 1'b1;
      else
        st_nxt.addon[m] = st_r.fast;
    end

    // Renumbering happens only on a change, so output clears are not repeated.
    st_nxt.clr = 1'b0;
    if (MOD_PRESENT_I != st_r.pres || MOD_TYPE_I != st_r.types)
    begin
      st_nxt.pres  = MOD_PRESENT_I;
      st_nxt.types = MOD_TYPE_I;
      st_nxt.clr   = 1'b1;
      for (int m = 0; m < `SLE_SLOTS; m++)
      begin
        // A gap ends the chain; modules beyond it cannot talk to the base.
        chain = chain & MOD_PRESENT_I[m];
        st_nxt.base[m] = acc;
        if (chain)
          acc = acc + sle_pins(MOD_TYPE_I[2*m +: 2]);
      end
      st_nxt.total = acc;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign POWER_INDICATOR_O       = st_r.pwr_led;
  assign LINK_INDICATOR_O        = st_r.link_led;
  assign CAN_RED_O               = st_r.red;
  assign CAN_YEL_O               = st_r.yel;
  assign ADDON_POWER_INDICATOR_O = st_r.addon;
  assign PIN_BASE_O              = st_r.base;
  assign PIN_TOTAL_O             = st_r.total;
  assign OUT_CLEAR_O             = st_r.clr;

  default clocking sle_cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  sequence sle_cfg_change;
    MOD_PRESENT_I != st_r.pres || MOD_TYPE_I != st_r.types;
  endsequence

  // The second cycle may only clear again if the set changed once more in the first cycle.
  sequence sle_clear_pulse;
    OUT_CLEAR_O ##1 (!OUT_CLEAR_O || $past(MOD_PRESENT_I, 2) != $past(MOD_PRESENT_I)
                     || $past(MOD_TYPE_I, 2) != $past(MOD_TYPE_I));
  endsequence

  a_power_steady: assert property (
    PWR_OK_I |=> POWER_INDICATOR_O)
    else $error("power indicator not on while powered");

  a_link_lease_fast: assert property (
    (!NET_CONNECTED_I && !NET_READY_I && NET_WAIT_LEASE_I) |=> LINK_INDICATOR_O == $past(st_r.fast))
    else $error("link indicator not fast flashing while awaiting lease");

  a_link_ready_slow: assert property (
    (!NET_CONNECTED_I && NET_READY_I) |=> LINK_INDICATOR_O == $past(st_r.slow))
    else $error("link indicator not slow flashing while ready");

  a_link_conn_steady: assert property (
    NET_CONNECTED_I ##1 NET_CONNECTED_I |=> LINK_INDICATOR_O && $past(LINK_INDICATOR_O, 1) == 1'b1)
    else $error("link indicator not steady while connected");

  a_can_busoff_blink: assert property (
    (CAN_BUS_OFF_I[1] && st_r.flash_cnt[1] == 6'h00)
      |=> CAN_RED_O[1] == $past(st_r.slower) && CAN_YEL_O[1] == $past(st_r.slow))
    else $error("bus off pattern wrong on channel 1");

  a_can_short_flash: assert property (
    CAN_ERR_FRAME_I[2] |=> st_r.flash_cnt[2] == `SLE_SHORT_MS ##1 CAN_RED_O[2])
    else $error("error frame flash missing on channel 2");

  a_addon_steady_on: assert property (
    (MOD_PRESENT_I[2] && MOD_COMM_I[2]) |=> ADDON_POWER_INDICATOR_O[2])
    else $error("add-on indicator not steady while communicating");

  a_addon_no_comm: assert property (
    (MOD_PRESENT_I[3] && !MOD_COMM_I[3]) |=> ADDON_POWER_INDICATOR_O[3] == $past(st_r.fast))
    else $error("add-on indicator not flashing without communication");

  a_enum_max_total: assert property (
    PIN_TOTAL_O <= 4 * `SLE_PINS_DIGITAL && PIN_BASE_O[7:0] == 8'h00)
    else $error("enumeration exceeds four modules or first base not zero");

  a_enum_consecutive: assert property (
    (sle_cfg_change and (MOD_PRESENT_I[1:0] == 2'h3))
      |=> PIN_BASE_O[15:8] == sle_pins(st_r.types[1:0]))
    else $error("second module base is not first module pin count");

  a_reenum_clear: assert property (
    sle_cfg_change |=> sle_clear_pulse)
    else $error("configuration change did not give one clear pulse");

  a_tick_spacing: assert property (
    st_r.tick |=> !st_r.tick [*8])
    else $error("base tick faster than expected");

endmodule : sle_top

// ---- sle_addon_chain.sv ----
`include "sle_params.svh"

module sle_addon_chain (
  // Bench side
  input  wire logic       clk_i,
  input  wire logic [3:0] fit_i,
  input  wire logic [7:0] kind_i,
  input  wire logic [3:0] talk_i,
  // Base side
  output logic      [3:0] present_o,
  output logic      [7:0] type_o,
  output logic      [3:0] comm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // An empty slot reports no type and cannot talk, so stale codes never leak.
  always_ff @(posedge clk_i)
  begin
    present_o <= fit_i;
    comm_o    <= fit_i & talk_i;
    for (int m = 0; m < `SLE_SLOTS; m++)
      type_o[2*m+:2] <= fit_i[m] ? kind_i[2*m+:2] : `SLE_TYPE_NONE;
  end
endmodule : sle_addon_chain

// ---- sle_top_bench.sv ----
`include "sle_params.svh"

module sle_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10;
  logic        CLK_I, RST_B_I, PWR_OK_I, NET_WAIT_LEASE_I, NET_READY_I, NET_CONNECTED_I;
  logic [3:0]  CAN_ERR_PASSIVE_I, CAN_BUS_OFF_I, CAN_ERR_FRAME_I, MOD_PRESENT_I, MOD_COMM_I;
  logic [3:0]  CAN_RED_O, CAN_YEL_O, ADDON_POWER_INDICATOR_O, fit, talk, rp;
  logic [7:0]  MOD_TYPE_I, PIN_TOTAL_O, kind, rt;
  logic [31:0] PIN_BASE_O;
  logic        POWER_INDICATOR_O, LINK_INDICATOR_O, OUT_CLEAR_O;
  logic [13:0] mon;
  int          error_cnt, n_checks, n;
  assign mon = {ADDON_POWER_INDICATOR_O, CAN_YEL_O, CAN_RED_O, LINK_INDICATOR_O,
                POWER_INDICATOR_O};

  sle_top #(.TICK_CYC(TK)) dut_u (.CLK_I, .RST_B_I, .PWR_OK_I, .NET_WAIT_LEASE_I,
    .NET_READY_I, .NET_CONNECTED_I, .CAN_ERR_PASSIVE_I, .CAN_BUS_OFF_I, .CAN_ERR_FRAME_I,
    .MOD_PRESENT_I, .MOD_TYPE_I, .MOD_COMM_I, .POWER_INDICATOR_O, .LINK_INDICATOR_O,
    .CAN_RED_O, .CAN_YEL_O, .ADDON_POWER_INDICATOR_O, .PIN_BASE_O, .PIN_TOTAL_O,
    .OUT_CLEAR_O);
  sle_addon_chain chain_u (.clk_i(CLK_I), .fit_i(fit), .kind_i(kind), .talk_i(talk),
    .present_o(MOD_PRESENT_I), .type_o(MOD_TYPE_I), .comm_o(MOD_COMM_I));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // Counts cycles until the watched indicator changes; a stuck one ends the run.
  task automatic flip(input int b, output int k);
    logic v;
    v = mon[b];
    k = 0;
    while (mon[b] === v && k < 30000)
    begin
      @(negedge CLK_I);
      k++;
    end
    if (k >= 30000)
    begin
      error_cnt++;
      $display("CHECK FAILED indicator %0d expected toggle seen none", b);
      report_and_stop();
    end
  endtask : flip

  // The first toggle may only be the pattern switch, so the third one is measured.
  task automatic half(input string what, input int b, input int exp);
    int k;
    flip(b, k);
    flip(b, k);
    flip(b, k);
    check(what, k, exp);
  endtask : half

  task automatic steady(input string what, input int b, input logic v);
    int k;
    k = 0;
    repeat (3) @(negedge CLK_I);
    repeat (2000)
    begin
      @(negedge CLK_I);
      if (mon[b] === v) k++;
    end
    check(what, k, 2000);
  endtask : steady

  function automatic int pins(input logic [1:0] t);
    case (t)
      `SLE_TYPE_DIGITAL: return `SLE_PINS_DIGITAL;
      `SLE_TYPE_ANALOG:  return `SLE_PINS_ANALOG;
      `SLE_TYPE_RELAY:   return `SLE_PINS_RELAY;
      default:           return 0;
    endcase
  endfunction : pins

  task automatic enum_cfg(input logic [3:0] p, input logic [7:0] t);
    logic [31:0] eb;
    int          run;
    bit          chain;
    run = 0;
    chain = 1;
    for (int m = 0; m < 4; m++)
    begin
      eb[8*m+:8] = run[7:0];
      if (chain && p[m]) run += pins(t[2*m+:2]);
      else chain = 0;
    end
    @(posedge CLK_I);
    fit  <= p;
    kind <= t;
    n = 0;
    do
    begin
      @(negedge CLK_I);
      n++;
    end
    while (OUT_CLEAR_O !== 1'b1 && n < 8);
    check("clear pulse", OUT_CLEAR_O, 1);
    if (OUT_CLEAR_O !== 1'b1)
      report_and_stop();
    check("pin bases", PIN_BASE_O, eb);
    check("pin total", PIN_TOTAL_O, run[7:0]);
    @(negedge CLK_I);
    check("clear width", OUT_CLEAR_O, 0);
  endtask : enum_cfg

  initial
  begin
    CLK_I = 0;
    forever #20 CLK_I = ~CLK_I;
  end

  initial
  begin
    {RST_B_I, PWR_OK_I, NET_WAIT_LEASE_I, NET_READY_I, NET_CONNECTED_I} = '0;
    {CAN_ERR_PASSIVE_I, CAN_BUS_OFF_I, CAN_ERR_FRAME_I, fit, talk, kind} = '0;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(32'h682c));
    repeat (4) @(posedge CLK_I);
    RST_B_I  <= 1'b1;
    PWR_OK_I <= 1'b1;
    steady("power indicator", 0, 1'b1);
    $display("test power done");
    @(posedge CLK_I) NET_WAIT_LEASE_I <= 1'b1;
    half("link fast", 1, TK * `SLE_FAST_HALF_MS);
    @(posedge CLK_I) NET_READY_I <= 1'b1;
    half("link slow", 1, TK * `SLE_SLOW_HALF_MS);
    @(posedge CLK_I) NET_CONNECTED_I <= 1'b1;
    steady("link steady", 1, 1'b1);
    $display("test link done");
    @(posedge CLK_I);
    CAN_ERR_PASSIVE_I <= 4'h3;
    CAN_BUS_OFF_I     <= 4'h2;
    half("passive red", 2, TK * `SLE_SLOW_HALF_MS);
    check("passive yellow", CAN_YEL_O[0], CAN_RED_O[0]);
    half("bus off red", 3, TK * `SLE_SLOWER_HALF_MS);
    @(posedge CLK_I) CAN_ERR_FRAME_I <= 4'h4;
    @(posedge CLK_I) CAN_ERR_FRAME_I <= 4'h0;
    flip(4, n);
    check("flash delay", n, 2);
    flip(4, n);
    check("flash length", n inside {[(`SLE_SHORT_MS-1)*TK:`SLE_SHORT_MS*TK+1]}, 1);
    $display("test can done");
    enum_cfg(4'h1, 8'h02);
    enum_cfg(4'h3, 8'h06);
    enum_cfg(4'h1, 8'h01);
    enum_cfg(4'h3, 8'h09);
    enum_cfg(4'hf, 8'h55);
    enum_cfg(4'hd, 8'h73);
    repeat (12)
    begin
      do
      begin
        rp = 4'($urandom);
        rt = 8'($urandom) & {{2{rp[3]}}, {2{rp[2]}}, {2{rp[1]}}, {2{rp[0]}}};
      end
      while ({rp, rt} == {fit, kind} || {rp, rt} == 12'h715);
      enum_cfg(rp, rt);
    end
    $display("test enumeration done");
    enum_cfg(4'h7, 8'h15);
    @(posedge CLK_I) talk <= 4'h5;
    steady("addon talking", 10, 1'b1);
    half("addon silent", 11, TK * `SLE_FAST_HALF_MS);
    steady("addon absent", 13, 1'b0);
    $display("test addon done");
    @(posedge CLK_I) RST_B_I <= 1'b0;
    @(negedge CLK_I);
    check("reset indicators", mon, 0);
    check("reset bases", PIN_BASE_O, 0);
    @(posedge CLK_I) RST_B_I <= 1'b1;
    repeat (2) @(negedge CLK_I);
    check("reset clear", OUT_CLEAR_O, 1);
    check("reset renumber", PIN_BASE_O, 32'h60402000);
    $display("test reset done");
    report_and_stop();
  end
endmodule : sle_top_bench
